/* File: rtl/phy_regs_pkg.sv */
// Package: register map, fields, reset values and carrier types
`default_nettype none
package phy_regs_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int REG_W  = 16;

  // Register indices; the byte address is four times the index
  localparam int IDX_PHY_STATUS    = 'h10;
  localparam int IDX_SELFTEST_MODE = 'h16;
  localparam int IDX_PHY_CONTROL   = 'h19;
  localparam int IDX_TEN_BASE      = 'h1a;
  localparam int IDX_SELFTEST_ONE  = 'h1b;

  // Field positions
  localparam int CTL_LED_MODE_BIT = 5;
  localparam int CTL_ADDR_LSB     = 0;
  localparam int PHY_ADDR_W       = 5;
  localparam int TEN_LOWTHR_BIT   = 13;
  localparam int TEN_SQ_LSB       = 9;
  localparam int SQ_W             = 4;
  localparam int TEN_NLP_BIT      = 7;
  localparam int TEN_POL_BIT      = 4;
  localparam int TEN_JAB_BIT      = 0;
  localparam int STS_POL_BIT      = 12;
  localparam int BIST_LOCK_BIT    = 15;
  localparam int BIST_CNT_LSB     = 8;
  localparam int CNT_W            = 8;
  localparam int BIST_IPG_LSB     = 0;
  localparam int IPG_W            = 8;
  localparam int MODE_WRAP_BIT    = 0;

  // Reset values and the saturation limit of the error count
  localparam logic                  LED_MODE_RST = 1'h1;
  localparam logic [PHY_ADDR_W-1:0] PHY_ADDR_RST = 5'h01;
  localparam logic [SQ_W-1:0]       SQ_RST       = 4'h0;
  localparam logic [IPG_W-1:0]      IPG_RST      = 8'h7d;
  localparam logic [CNT_W-1:0]      CNT_MAX      = 8'hff;

  // Activity blink timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int BLINK_HALF_NS  = 50_000_000;
  localparam int BLINK_HALF_CYC = BLINK_HALF_NS / CLK_PERIOD_NS;
  localparam int BLINK_W        = 23;

  typedef struct packed {
    logic link_up;
    logic activity;
    logic pol_event;
    logic prbs_err;
    logic ten_mode;
  } phy_in_t;

  typedef struct packed {
    logic [PHY_ADDR_W-1:0] phy_addr;
    logic                  led_mode;
  } strap_t;

  typedef struct packed {
    logic             rx_low_threshold;
    logic [SQ_W-1:0]  squelch_level;
    logic             nlp_tx_disable;
    logic             jabber_disable;
    logic [IPG_W-1:0] ipg_len;
  } phy_cfg_t;

  typedef struct packed {
    logic [CNT_W-1:0] running;
    logic [CNT_W-1:0] frozen;
  } err_cnt_t;

endpackage
`default_nettype wire

/* File: rtl/err_counter.sv */
// Errored-byte counter with lock-and-clear and optional saturation
`default_nettype none
module err_counter (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  err_pulse,
  input  wire logic                  lock_clear,
  input  wire logic                  wrap_mode,
  output var  phy_regs_pkg::err_cnt_t cnt
);
  import phy_regs_pkg::*;

  err_cnt_t st_r;
  err_cnt_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (lock_clear) begin
      // An error in the lock cycle starts the new count, so none is lost
      st_nxt.frozen  = st_r.running;
      st_nxt.running = {{(CNT_W-1){1'b0}}, err_pulse};
    end else if (err_pulse) begin
      if (wrap_mode || st_r.running != CNT_MAX) begin
        st_nxt.running = CNT_W'(st_r.running + 1'b1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cnt = st_r;

  lock_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    lock_clear |=> st_r.frozen == $past(st_r.running)
                   && st_r.running == CNT_W'($past(err_pulse)))
    else $error("lock did not freeze and clear the count");

  saturate_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!wrap_mode && !lock_clear && st_r.running == CNT_MAX)
      |=> st_r.running == CNT_MAX)
    else $error("error count left saturation");

endmodule
`default_nettype wire

/* File: rtl/phy_ctrl_10bt_bist_regs.sv */
// PHY control, 10BASE-Te control and first self-test register bank on APB
`default_nettype none
module phy_ctrl_10bt_bist_regs #(
  parameter int BLINK_CYC = phy_regs_pkg::BLINK_HALF_CYC
) (
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [phy_regs_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [phy_regs_pkg::DATA_W-1:0]   pwdata,
  output logic      [phy_regs_pkg::DATA_W-1:0]   prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire phy_regs_pkg::phy_in_t             phy_in,
  input  wire phy_regs_pkg::strap_t              strap,
  output phy_regs_pkg::phy_cfg_t                 phy_cfg,
  output logic                                   link_led_out
);
  import phy_regs_pkg::*;

  typedef struct packed {
    logic                  strap_done;
    logic                  led_mode;
    logic [PHY_ADDR_W-1:0] phy_addr;
    logic                  low_thr;
    logic [SQ_W-1:0]       squelch;
    logic                  nlp_dis;
    logic                  jab_dis;
    logic                  pol;
    logic                  pol_seen;
    logic                  wrap_mode;
    logic [IPG_W-1:0]      ipg;
    logic [REG_W-1:0]      rdata;
    logic                  err;
    logic                  jab_out;
    logic                  led;
    logic [BLINK_W-1:0]    blink_cnt;
    logic                  blink_phase;
    logic                  act_seen;
    logic                  act_prev;
  } regs_state_t;

  regs_state_t st_r;
  regs_state_t st_nxt;
  err_cnt_t    cnt;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input int idx);
    hit = (a == ADDR_W'(idx * 4));
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, IDX_PHY_STATUS) || hit(a, IDX_SELFTEST_MODE)
          || hit(a, IDX_PHY_CONTROL) || hit(a, IDX_TEN_BASE)
          || hit(a, IDX_SELFTEST_ONE);
  endfunction

  logic setup_ph;
  logic wr_acc;
  logic rd_acc;
  logic lock_clear;
  logic blink_wrap;
  logic ten_rd;

  // Zero wait states: the access phase always completes
  assign pready     = 1'b1;
  assign setup_ph   = psel && !penable;
  assign wr_acc     = psel && penable && pwrite;
  assign rd_acc     = psel && penable && !pwrite;
  assign ten_rd     = rd_acc && hit(paddr, IDX_TEN_BASE);
  assign lock_clear = wr_acc && hit(paddr, IDX_SELFTEST_ONE)
                      && pwdata[BIST_LOCK_BIT];
  assign blink_wrap = (st_r.blink_cnt == BLINK_W'(BLINK_CYC - 1));

  err_counter u_err_counter (
    .pclk       (pclk),
    .presetn    (presetn),
    .err_pulse  (phy_in.prbs_err),
    .lock_clear (lock_clear),
    .wrap_mode  (st_r.wrap_mode),
    .cnt        (cnt)
  );

  always_comb begin
    st_nxt = st_r;

    // Straps are caught on the first edge after reset release
    if (!st_r.strap_done) begin
      st_nxt.strap_done = 1'b1;
      st_nxt.phy_addr   = strap.phy_addr;
      st_nxt.led_mode   = strap.led_mode;
    end

    // Read data is built in the setup cycle so it comes from a flop
    if (setup_ph) begin
      st_nxt.rdata    = '0;
      st_nxt.err      = !mapped(paddr);
      st_nxt.pol_seen = 1'b0;
      if (hit(paddr, IDX_PHY_STATUS)) begin
        st_nxt.rdata[STS_POL_BIT] = st_r.pol;
      end
      if (hit(paddr, IDX_SELFTEST_MODE)) begin
        st_nxt.rdata[MODE_WRAP_BIT] = st_r.wrap_mode;
      end
      if (hit(paddr, IDX_PHY_CONTROL)) begin
        st_nxt.rdata[CTL_LED_MODE_BIT] = st_r.led_mode;
        st_nxt.rdata[CTL_ADDR_LSB +: PHY_ADDR_W] = st_r.phy_addr;
      end
      if (hit(paddr, IDX_TEN_BASE)) begin
        st_nxt.rdata[TEN_LOWTHR_BIT]       = st_r.low_thr;
        st_nxt.rdata[TEN_SQ_LSB +: SQ_W]   = st_r.squelch;
        st_nxt.rdata[TEN_NLP_BIT]          = st_r.nlp_dis;
        st_nxt.rdata[TEN_POL_BIT]          = st_r.pol;
        st_nxt.rdata[TEN_JAB_BIT]          = st_r.jab_dis;
        st_nxt.pol_seen                    = st_r.pol;
      end
      if (hit(paddr, IDX_SELFTEST_ONE)) begin
        st_nxt.rdata[BIST_CNT_LSB +: CNT_W] = cnt.frozen;
        st_nxt.rdata[BIST_IPG_LSB +: IPG_W] = st_r.ipg;
      end
    end

    // Writes take effect at the access edge; reserved bits are dropped
    if (wr_acc) begin
      if (hit(paddr, IDX_SELFTEST_MODE)) begin
        st_nxt.wrap_mode = pwdata[MODE_WRAP_BIT];
      end
      if (hit(paddr, IDX_PHY_CONTROL)) begin
        st_nxt.led_mode = pwdata[CTL_LED_MODE_BIT];
      end
      if (hit(paddr, IDX_TEN_BASE)) begin
        st_nxt.low_thr = pwdata[TEN_LOWTHR_BIT];
        st_nxt.squelch = pwdata[TEN_SQ_LSB +: SQ_W];
        st_nxt.nlp_dis = pwdata[TEN_NLP_BIT];
        st_nxt.jab_dis = pwdata[TEN_JAB_BIT];
      end
      if (hit(paddr, IDX_SELFTEST_ONE)) begin
        st_nxt.ipg = pwdata[BIST_IPG_LSB +: IPG_W];
      end
    end

    // Only a value that was reported is cleared; a new event still sets
    if (ten_rd) begin
      st_nxt.pol = st_r.pol && !st_r.pol_seen;
    end
    if (phy_in.pol_event) begin
      st_nxt.pol = 1'b1;
    end

    st_nxt.jab_out = st_r.jab_dis && phy_in.ten_mode;

    // Blink is slow enough to see; activity in a half period blinks the next one only when blink_phase is set in it
    if (blink_wrap) begin
      st_nxt.blink_cnt   = '0;
      st_nxt.blink_phase = !st_r.blink_phase;
      st_nxt.act_prev    = st_r.act_seen || phy_in.activity;
      st_nxt.act_seen    = 1'b0;
    end else begin
      st_nxt.blink_cnt = BLINK_W'(st_r.blink_cnt + 1'b1);
      if (phy_in.activity) begin
        st_nxt.act_seen = 1'b1;
      end
    end

    if (st_r.led_mode) begin
      st_nxt.led = phy_in.link_up;
    end else begin
      st_nxt.led = phy_in.link_up
                   && !(st_r.act_prev && st_r.blink_phase);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r          <= '0;
      st_r.led_mode <= LED_MODE_RST;
      st_r.phy_addr <= PHY_ADDR_RST;
      st_r.squelch  <= SQ_RST;
      st_r.ipg      <= IPG_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata  = {{(DATA_W-REG_W){1'b0}}, st_r.rdata};
  assign pslverr = psel && penable && st_r.err;

  assign phy_cfg.rx_low_threshold = st_r.low_thr;
  assign phy_cfg.squelch_level    = st_r.squelch;
  assign phy_cfg.nlp_tx_disable   = st_r.nlp_dis;
  assign phy_cfg.jabber_disable   = st_r.jab_out;
  assign phy_cfg.ipg_len          = st_r.ipg;
  assign link_led_out             = st_r.led;

  led_link_only_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_r.led_mode |=> link_led_out == $past(phy_in.link_up))
    else $error("link-only LED does not follow link");

  led_no_link_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !phy_in.link_up |=> !link_led_out)
    else $error("LED lit without link");

  low_thr_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_acc && hit(paddr, IDX_TEN_BASE))
      |=> phy_cfg.rx_low_threshold == $past(pwdata[TEN_LOWTHR_BIT]))
    else $error("low threshold not written");

  squelch_wr_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_acc && hit(paddr, IDX_TEN_BASE))
      |=> phy_cfg.squelch_level == $past(pwdata[TEN_SQ_LSB +: SQ_W]))
    else $error("squelch code not written");

  nlp_wr_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_acc && hit(paddr, IDX_TEN_BASE))
      |=> phy_cfg.nlp_tx_disable == $past(pwdata[TEN_NLP_BIT]))
    else $error("link pulse control not written");

  pol_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ten_rd && !phy_in.pol_event && !$past(phy_in.pol_event)) |=> !st_r.pol)
    else $error("polarity not cleared by read");

  pol_keep_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st_r.pol && !ten_rd) |=> st_r.pol)
    else $error("polarity lost without ten-base read");

  jabber_mode_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !phy_in.ten_mode |=> !phy_cfg.jabber_disable)
    else $error("jabber disable outside ten-base mode");

  cnt_read_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && hit(paddr, IDX_SELFTEST_ONE))
      |=> prdata[BIST_CNT_LSB +: CNT_W] == $past(cnt.frozen))
    else $error("count field read wrong");

  ipg_wr_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_acc && hit(paddr, IDX_SELFTEST_ONE))
      |=> phy_cfg.ipg_len == $past(pwdata[BIST_IPG_LSB +: IPG_W]))
    else $error("gap length not written");

  addr_ro_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_r.strap_done |=> $stable(st_r.phy_addr))
    else $error("strapped address changed");

  resv_zero_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && hit(paddr, IDX_TEN_BASE))
      |=> prdata[15:14] == 2'h0 && prdata[8] == 1'h0
          && prdata[6:5] == 2'h0 && prdata[3:1] == 3'h0
          && prdata[31:16] == 16'h0)
    else $error("reserved bits not zero");

  led_mode_wr_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_acc && hit(paddr, IDX_PHY_CONTROL))
      |=> st_r.led_mode == $past(pwdata[CTL_LED_MODE_BIT]))
    else $error("link LED mode not written");

  squelch_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(wr_acc && hit(paddr, IDX_TEN_BASE)) |=> $stable(phy_cfg.squelch_level))
    else $error("squelch code changed without a write");

  squelch_rd_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && hit(paddr, IDX_TEN_BASE))
      |=> prdata[TEN_SQ_LSB +: SQ_W] == $past(phy_cfg.squelch_level))
    else $error("squelch code read wrong");

  pol_set_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    phy_in.pol_event |=> st_r.pol)
    else $error("polarity event not recorded");

  status_pol_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && hit(paddr, IDX_PHY_STATUS))
      |=> prdata[STS_POL_BIT] == $past(st_r.pol))
    else $error("status polarity copy read wrong");

  ten_pol_rd_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && hit(paddr, IDX_TEN_BASE))
      |=> prdata[TEN_POL_BIT] == $past(st_r.pol))
    else $error("ten-base polarity read wrong");

  jab_on_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (phy_in.ten_mode && st_r.jab_dis) |=> phy_cfg.jabber_disable)
    else $error("jabber disable not applied in ten-base mode");

  jab_wr_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_acc && hit(paddr, IDX_TEN_BASE))
      |=> st_r.jab_dis == $past(pwdata[TEN_JAB_BIT]))
    else $error("jabber control not written");

  ipg_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(wr_acc && hit(paddr, IDX_SELFTEST_ONE)) |=> $stable(phy_cfg.ipg_len))
    else $error("gap length changed without a write");

  ipg_rd_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && hit(paddr, IDX_SELFTEST_ONE))
      |=> prdata[BIST_IPG_LSB +: IPG_W] == $past(st_r.ipg))
    else $error("gap length read wrong");

  addr_rd_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && hit(paddr, IDX_PHY_CONTROL))
      |=> prdata[CTL_ADDR_LSB +: PHY_ADDR_W] == $past(st_r.phy_addr))
    else $error("strapped address read wrong");

  ctl_resv_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && hit(paddr, IDX_PHY_CONTROL))
      |=> prdata[31:6] == 26'h0)
    else $error("control reserved bits not zero");

  unmapped_rd_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && !mapped(paddr)) |=> prdata == 32'h0 && st_r.err)
    else $error("unmapped read not flagged");

  unmapped_wr_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_acc && !mapped(paddr))
      |=> $stable(st_r.ipg) && $stable(st_r.squelch)
          && $stable(st_r.nlp_dis) && $stable(st_r.jab_dis))
    else $error("unmapped write changed a setting");

endmodule
`default_nettype wire

/* File: tb/phy_side_model.sv */
// Line side model: turns bench requests into line levels and event pulses
`default_nettype none
module phy_side_model (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                link,
  input  wire logic                act,
  input  wire logic                ten,
  input  wire logic                pol_req,
  input  wire logic                err_req,
  output var  phy_regs_pkg::phy_in_t phy_in
);
  timeunit 1ns;
  timeprecision 100ps;
  import phy_regs_pkg::*;
  // One pulse per cycle of request, so a held request is a burst of events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phy_in <= '0;
    end else begin
      phy_in.link_up   <= link;
      phy_in.activity  <= act;
      phy_in.ten_mode  <= ten;
      phy_in.pol_event <= pol_req;
      phy_in.prbs_err  <= err_req;
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the PHY control, ten-base and self-test bank
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import phy_regs_pkg::*;
  logic              pclk    = 1'b0;
  logic              presetn = 1'b0;
  logic              psel    = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite  = 1'b0;
  logic [ADDR_W-1:0] paddr   = '0;
  logic [DATA_W-1:0] pwdata  = '0;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              link_led_out;
  logic              link    = 1'b0;
  logic              act     = 1'b0;
  logic              ten     = 1'b0;
  logic              pol_req = 1'b0;
  logic              err_req = 1'b0;
  phy_in_t           phy_in;
  strap_t            strap   = 6'h15;
  phy_cfg_t          phy_cfg;
  logic [DATA_W-1:0] q;
  logic              e;
  int                bad_count = 0;
  int                tests_run = 0;
  int                cyc       = 0;

  phy_ctrl_10bt_bist_regs #(.BLINK_CYC(8)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .phy_in(phy_in), .strap(strap),
    .phy_cfg(phy_cfg), .link_led_out(link_led_out)
  );
  phy_side_model line (
    .pclk(pclk), .presetn(presetn), .link(link), .act(act), .ten(ten),
    .pol_req(pol_req), .err_req(err_req), .phy_in(phy_in)
  );

  initial begin
    forever #5 pclk = ~pclk;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Ceiling well above the nine hundred or so cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 8000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] x,
                     input string m);
    tests_run++;
    if (got !== x) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  // Wait states are honoured by polling pready; a stuck pready is cut off by the ceiling
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input string m);
    apb(1'b0, a, 32'h0);
    chk(q, x, m);
  endtask

  task automatic t_reset();
    rd(8'h64, 32'h2a, "control reset");
    rd(8'h68, 32'h0, "ten-base reset");
    rd(8'h6c, 32'h7d, "self-test reset");
    chk(32'(phy_cfg), 32'h7d, "config reset");
    $display("done reset");
  endtask

  task automatic t_ctl();
    apb(1'b1, 8'h64, 32'hffff_ffdf);
    rd(8'h64, 32'h0a, "address kept");
    apb(1'b1, 8'h64, 32'h20);
    rd(8'h64, 32'h2a, "led mode back");
    $display("done control");
  endtask

  task automatic t_ten();
    ten <= 1'b1;
    apb(1'b1, 8'h68, 32'hffff_ffff);
    rd(8'h68, 32'h3e81, "ten-base fields");
    chk(32'(phy_cfg), 32'h7f7d, "config all set");
    ten <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(32'(phy_cfg.jabber_disable), 32'h0, "jabber outside");
    for (int c = 0; c < 9; c++) begin
      apb(1'b1, 8'h68, 32'(c) << 9);
      @(posedge pclk);
      chk(32'(phy_cfg.squelch_level), 32'(c), "squelch");
    end
    chk(32'(phy_cfg.rx_low_threshold), 32'h0, "threshold");
    chk(32'(phy_cfg.nlp_tx_disable), 32'h0, "link pulses");
    $display("done ten-base");
  endtask

  task automatic t_pol();
    pol_req <= 1'b1;
    @(posedge pclk);
    pol_req <= 1'b0;
    repeat (3) @(posedge pclk);
    rd(8'h40, 32'h1000, "status flag");
    rd(8'h40, 32'h1000, "status kept");
    rd(8'h68, 32'h1010, "ten-base flag");
    rd(8'h68, 32'h1000, "ten-base cleared");
    rd(8'h40, 32'h0, "status cleared");
    $display("done polarity");
  endtask

  task automatic errs(input int n);
    err_req <= 1'b1;
    repeat (n) @(posedge pclk);
    err_req <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic t_err();
    errs(10);
    apb(1'b1, 8'h6c, 32'h807d);
    rd(8'h6c, 32'h0a7d, "count ten");
    errs(300);
    apb(1'b1, 8'h6c, 32'h807d);
    rd(8'h6c, 32'hff7d, "saturated");
    apb(1'b1, 8'h58, 32'h1);
    rd(8'h58, 32'h1, "wrap mode set");
    errs(260);
    apb(1'b1, 8'h6c, 32'h807d);
    rd(8'h6c, 32'h047d, "wrapped");
    apb(1'b1, 8'h6c, 32'h807d);
    rd(8'h6c, 32'h007d, "cleared");
    errs(5);
    apb(1'b1, 8'h6c, 32'h0042);
    rd(8'h6c, 32'h0042, "no lock");
    chk(32'(phy_cfg.ipg_len), 32'h42, "gap");
    apb(1'b1, 8'h6c, 32'h8042);
    rd(8'h6c, 32'h0542, "kept running");
    $display("done error count");
  endtask

  task automatic offs(input logic [31:0] x, input string m);
    int k;
    k = 0;
    repeat (32) begin
      @(posedge pclk);
      if (link_led_out !== 1'b1) k++;
    end
    chk(32'(k), x, m);
  endtask

  task automatic t_led();
    link <= 1'b1;
    act  <= 1'b1;
    repeat (3) @(posedge pclk);
    offs(32'd0, "link only");
    apb(1'b1, 8'h64, 32'h0);
    repeat (3) @(posedge pclk);
    offs(32'd16, "blinking");
    act <= 1'b0;
    repeat (20) @(posedge pclk);
    offs(32'd0, "quiet link");
    link <= 1'b0;
    repeat (3) @(posedge pclk);
    offs(32'd32, "no link");
    $display("done led");
  endtask

  task automatic t_bad();
    rd(8'h00, 32'h0, "unmapped read");
    chk(32'(e), 32'h1, "unmapped error");
    apb(1'b1, 8'h70, 32'hffff_ffff);
    rd(8'h6c, 32'h0542, "write ignored");
    chk(32'(e), 32'h0, "mapped no error");
    $display("done unmapped");
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_reset();
    t_ctl();
    t_ten();
    t_pol();
    t_err();
    t_led();
    t_bad();
    wrap_up();
  end
endmodule
`default_nettype wire
